// ===== bench/clk_rst_core_asserts.sv
module clk_rst_core_asserts
    import clk_rst_pkg::*;
(
    input wire logic             clk_in,
    input wire logic             nrst_in,
    input wire logic             glob_nrst_in,
    input wire logic             srst_in,
    input wire logic             crst_in,
    input wire link_stat_s       stat_in,
    input wire logic             sticky_we_in,
    input wire logic             cfg_we_in,
    input wire logic [CFG_W-1:0] cfg_wd_in,
    input wire logic [STICKY_W-1:0] sticky_out,
    input wire logic [CFG_W-1:0] cfg_out,
    input wire logic             dp_busy_out,
    input wire logic             l2_exit_n_out,
    input wire logic             hot_exit_n_out,
    input wire logic             dlup_exit_n_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    ////////////////////////////////////////////////////////////////
    // Link state departures, seen one edge late
    sequence left_l2;
        $past(stat_in.ltssm) == LTS_L2 && stat_in.ltssm != LTS_L2;
    endsequence
    sequence left_hot;
        $past(stat_in.ltssm) == LTS_HOTRST && stat_in.ltssm != LTS_HOTRST;
    endsequence
    sequence hot_pulse;
        !hot_exit_n_out ##1 hot_exit_n_out;
    endsequence
    AST_L2_EXIT: assert property (left_l2 |=> !l2_exit_n_out)
        else $error("low power exit missing");
    AST_HOT_PULSE: assert property (left_hot |=> hot_pulse)
        else $error("hot reset exit pulse wrong");
    AST_DLUP_EXIT: assert property ($fell(stat_in.dl_up) |=> !dlup_exit_n_out)
        else $error("link down exit missing");
    AST_DP_RESET: assert property (srst_in |=> !dp_busy_out)
        else $error("datapath reset ignored");
    AST_CFG_RESET: assert property (crst_in |=> cfg_out == CFG_RST)
        else $error("config reset ignored");
    AST_CFG_WRITE: assert property ((cfg_we_in && !crst_in && glob_nrst_in)
        ##1 glob_nrst_in |-> cfg_out == $past(cfg_wd_in))
        else $error("config write lost");
    AST_STICKY_HOLD: assert property ((srst_in || crst_in) && !sticky_we_in
        |=> $stable(sticky_out))
        else $error("sticky value disturbed");
    AST_GLOB_RESET: assert property (!glob_nrst_in |=> cfg_out == CFG_RST && !dp_busy_out)
        else $error("global reset ignored");
endmodule : clk_rst_core_asserts

bind clk_rst_core clk_rst_core_asserts i_clk_rst_core_asserts (.clk_in, .nrst_in,
    .glob_nrst_in, .srst_in, .crst_in, .stat_in, .sticky_we_in, .cfg_we_in, .cfg_wd_in,
    .sticky_out, .cfg_out, .dp_busy_out, .l2_exit_n_out, .hot_exit_n_out, .dlup_exit_n_out);

// ===== bench/rst_gen_model.sv
module rst_gen_model
    import clk_rst_pkg::*;
(
    input  wire logic  clk_in,
    input  wire logic  por_n_in,
    input  wire logic  perst_n_in,
    input  wire logic  srst_req_in,
    input  wire logic  crst_req_in,
    input  wire exit_s exit_in,
    output logic       nrst_out,
    output logic       srst_out,
    output logic       crst_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cold_q;
    // board reset joined with card reset
    assign nrst_out = por_n_in & perst_n_in;
    // any exit low, one cycle of both resets
    always_ff @(posedge clk_in or negedge nrst_out) begin
        if (!nrst_out) cold_q <= 1'h0;
        else cold_q <= ~&exit_in;
    end
    // Bench requests merged so table rows need no extra wiring
    assign srst_out = srst_req_in | cold_q;
    assign crst_out = crst_req_in | cold_q;
endmodule : rst_gen_model

// ===== bench/tb_clk_rst_core.sv
module tb_clk_rst_core;
    import clk_rst_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic s, c, sw, cw, eb;
        logic [15:0] sd, cd, es, ec;
    } row_s;
    localparam row_s ROWS [5] = '{{5'h07, 16'ha5a5, 16'h3c3c, 16'ha5a5, 16'h3c3c},
        {5'h18, 16'hffff, 16'hffff, 16'ha5a5, 16'h0000},
        {5'h0b, 16'h0000, 16'h1234, 16'ha5a5, 16'h0000},
        {5'h03, 16'h0000, 16'h00ff, 16'ha5a5, 16'h00ff},
        {5'h14, 16'hffff, 16'h0000, 16'hffff, 16'h00ff}};
    localparam link_stat_s EV_A [3] = '{'{LTS_L2, 1'h1}, '{LTS_HOTRST, 1'h1}, '{LTS_ACTIVE, 1'h1}};
    localparam link_stat_s EV_B [3] = '{'{LTS_ACTIVE, 1'h1}, '{LTS_ACTIVE, 1'h1}, '{LTS_ACTIVE, 1'h0}};
    logic clk_in = 1'h0, ref_clk = 1'h0, por_n = 1'h0, perst_n = 1'h1, glob_nrst = 1'h1;
    logic app_half = 1'h0;
    logic nrst, srst, crst, busy, dclk, d8, aclk, l2n, hotn, dlupn;
    logic [15:0] sticky, cfg;
    clk_src_e src = SRC_PIPE;
    link_stat_s stat = '{LTS_ACTIVE, 1'h1};
    row_s r = '0;
    exit_s ex;
    int failures = 0, checks_done = 0, cycles = 0;
    assign ex = {l2n, hotn, dlupn};
    clk_rst_core i_clk_rst_core (.clk_in, .nrst_in(nrst), .glob_nrst_in(glob_nrst),
        .ref_clk_in(ref_clk), .clk_src_in(src), .app_half_in(app_half), .srst_in(srst),
        .crst_in(crst), .stat_in(stat), .sticky_we_in(r.sw), .sticky_wd_in(r.sd),
        .cfg_we_in(r.cw), .cfg_wd_in(r.cd), .derived_clock_out_x1x4(dclk),
        .derived_clock_out_x8(d8), .app_clk_out(aclk), .sticky_out(sticky), .cfg_out(cfg),
        .dp_busy_out(busy), .l2_exit_n_out(l2n), .hot_exit_n_out(hotn),
        .dlup_exit_n_out(dlupn));
    rst_gen_model i_rst_gen_model (.clk_in, .por_n_in(por_n), .perst_n_in(perst_n),
        .srst_req_in(r.s), .crst_req_in(r.c), .exit_in(ex), .nrst_out(nrst),
        .srst_out(srst), .crst_out(crst));
    ////////////////////////////////////////////////////////////////
    // core clock at 125 MHz; reference free running
    // an x8 build feeds clk_in from the x8 output; this bench keeps x1/x4 timing
    always #4 clk_in = ~clk_in;
    always #5 ref_clk = ~ref_clk;
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    // Level changes of the derived clocks in one 80 ns window, off the edges
    task automatic count_edges(output int e8, output int ed, output int ea);
        logic p8, pd, pa;
        e8 = 0;
        ed = 0;
        ea = 0;
        #0.5;
        p8 = d8;
        pd = dclk;
        pa = aclk;
        repeat (80) begin
            #1;
            e8 += int'(d8 !== p8);
            ed += int'(dclk !== pd);
            ea += int'(aclk !== pa);
            p8 = d8;
            pd = dclk;
            pa = aclk;
        end
    endtask : count_edges
    // Hang guard, whole run needs well under 200 cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 1000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        int lows, hi, miss, n8, nd, na;
        repeat (2) @(negedge clk_in);
        por_n = 1'h1;
        repeat (3) @(negedge clk_in);
        for (int i = 0; i < 5; i++) begin
            r = ROWS[i];
            @(negedge clk_in);
            chk("sticky", ROWS[i].es, sticky);
            chk("cfg", ROWS[i].ec, cfg);
            chk("busy", {15'h0, ROWS[i].eb}, {15'h0, busy});
        end
        r = '0;
        $display("test table done");
        // Each exit kind: one low cycle, partner then clears config
        for (int k = 0; k < 3; k++) begin
            r.cw = 1'h1;
            r.cd = 16'h5555;
            @(negedge clk_in);
            r.cw = 1'h0;
            stat = EV_A[k];
            @(negedge clk_in);
            stat = EV_B[k];
            lows = 0;
            repeat (4) begin
                @(negedge clk_in);
                lows += int'(!ex[2-k]);
            end
            chk("exit_low_cycles", 16'h1, 16'(lows));
            chk("cfg_after_exit", CFG_RST, cfg);
            chk("sticky_after_exit", 16'hffff, sticky);
            stat = '{LTS_ACTIVE, 1'h1};
            @(negedge clk_in);
        end
        $display("test exits done");
        r.cw = 1'h1;
        r.cd = 16'h0f0f;
        @(negedge clk_in);
        r.cw = 1'h0;
        glob_nrst = 1'h0;
        #1;
        chk("cfg_glob", CFG_RST, cfg);
        chk("busy_glob", 16'h0, {15'h0, busy});
        @(negedge clk_in);
        glob_nrst = 1'h1;
        chk("sticky_glob", 16'hffff, sticky);
        $display("test global reset done");
        // Pipe source: the reference must show on the output unchanged
        hi = 0;
        miss = 0;
        #0.5;
        repeat (40) begin
            #1;
            hi += int'(dclk);
            miss += int'(dclk !== ref_clk);
        end
        chk("clock_runs", 16'h1, 16'(hi > 0 && hi < 40));
        chk("pass_through", 16'h0, 16'(miss));
        @(negedge clk_in);
        src = SRC_REF_100;
        repeat (6) @(negedge clk_in);
        count_edges(n8, nd, na);
        chk("derived_runs", 16'h1, 16'(nd > 0));
        chk("x8_rate", 16'(2 * nd), 16'(n8));
        chk("app_rate", 16'(nd), 16'(na));
        @(negedge clk_in);
        app_half = 1'h1;
        repeat (6) @(negedge clk_in);
        count_edges(n8, nd, na);
        chk("app_half_rate", 16'(nd), 16'(2 * na));
        $display("test derived clocks done");
        @(negedge clk_in);
        perst_n = 1'h0;
        hi = 0;
        repeat (40) #1 hi += int'(dclk | aclk);
        chk("clock_in_reset", 16'h0, 16'(hi));
        chk("sticky_por", STICKY_RST, sticky);
        $display("test power on reset done");
        wrap_up();
    end
endmodule : tb_clk_rst_core

// ===== hw/clk_rst_core.sv
module clk_rst_core
    import clk_rst_pkg::*;
(
    input  wire logic                clk_in,          // Core clock, 125 MHz
    input  wire logic                nrst_in,         // Power-on reset, active low
    input  wire logic                glob_nrst_in,    // x8 global reset, active low
    input  wire logic                ref_clk_in,      // Reference clock pin
    input  wire clk_src_e            clk_src_in,      // Static clock configuration
    input  wire logic                app_half_in,     // Static: app clock at 62.5 MHz
    input  wire logic                srst_in,         // Datapath reset, active high
    input  wire logic                crst_in,         // Config reset, active high
    input  wire link_stat_s          stat_in,         // Link layer status
    input  wire logic                sticky_we_in,
    input  wire logic [STICKY_W-1:0] sticky_wd_in,
    input  wire logic                cfg_we_in,
    input  wire logic [CFG_W-1:0]    cfg_wd_in,
    output logic                     derived_clock_out_x1x4,
    output logic                     derived_clock_out_x8,
    output logic                     app_clk_out,
    output logic [STICKY_W-1:0]      sticky_out,
    output logic [CFG_W-1:0]         cfg_out,
    output logic                     dp_busy_out,
    output logic                     l2_exit_n_out,
    output logic                     hot_exit_n_out,
    output logic                     dlup_exit_n_out
);

    ////////////////////////////////////////////////////////////////////////
    // Static pins and reset release on the reference domain
    ////////////////////////////////////////////////////////////////////////

    localparam int unsigned PIN_W = 3;

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_meta_q, pin_meta_d;
    logic [PIN_W-1:0] pin_sync_q, pin_sync_d;
    logic             ref_meta_q, ref_meta_d;
    logic             ref_nrst_q, ref_nrst_d;
    clk_src_e         src_sel;
    logic             half_sel;
    logic             pass_sel;

    // Source and rate pins gathered into one vector for the synchroniser
    assign pin_raw = {app_half_in, clk_src_in};

    // Two flops per pin; strapping pins settle long before they matter,
    // so no reset is needed and a late change only costs two edges
    for (genvar b = 0; b < PIN_W; b++) begin : g_pin_sync
        always_comb begin
            pin_meta_d[b] = pin_raw[b];
            pin_sync_d[b] = pin_meta_q[b];
        end

        always_ff @(posedge ref_clk_in) begin
            pin_meta_q[b] <= pin_meta_d[b];
            pin_sync_q[b] <= pin_sync_d[b];
        end
    end

    // Release stage inputs; only the second flop reads the first
    always_comb begin
        ref_meta_d = 1'b1;
        ref_nrst_d = ref_meta_q;
    end

    // R07 clocking reset, async assert and reference-synchronous release
    // Avoids a runt first divider pulse when power-on reset lets go
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ref_meta_q <= 1'b0;
            ref_nrst_q <= 1'b0;
        end else begin
            ref_meta_q <= ref_meta_d;
            ref_nrst_q <= ref_nrst_d;
        end
    end

    // Decode of the synchronised pins
    assign src_sel  = clk_src_e'(pin_sync_q[1:0]);
    assign half_sel = pin_sync_q[2];
    // R02 pipe and 125 MHz references need no derivation
    assign pass_sel = (src_sel == SRC_PIPE) || (src_sel == SRC_REF_125);

    ////////////////////////////////////////////////////////////////////////
    // Derived clocks on the reference domain
    ////////////////////////////////////////////////////////////////////////

    logic [1:0] div_q, div_d;
    logic       clk125_q, clk125_d;
    logic       clk250_q, clk250_d;
    logic       app_q, app_d;

    // Rates are modelled by dividing the reference; a real part uses a PLL.
    // Only the ratios are kept, and only with SRC_REF_100 or SRC_REF_15625: x8 at twice the x1/x4 rate, app at 1 or 1/2
    always_comb begin
        div_d    = div_q + 2'h1;
        // R03 derived output at half the x8 rate
        clk125_d = div_q[1];
        // R04 x8 derived clock
        clk250_d = ~clk250_q;
        // R11 application clock, full or half rate
        if (half_sel) begin
            app_d = app_q ^ (div_q == 2'h3);
        end else begin
            app_d = div_q[1];
        end
    end

    // R08 dividers parked low while power-on reset holds
    always_ff @(posedge ref_clk_in or negedge ref_nrst_q) begin
        if (!ref_nrst_q) begin
            div_q    <= DIV_RST;
            clk125_q <= 1'b0;
            clk250_q <= 1'b0;
            app_q    <= 1'b0;
        end else begin
            div_q    <= div_d;
            clk125_q <= clk125_d;
            clk250_q <= clk250_d;
            app_q    <= app_d;
        end
    end

    // R02 pass-through is a plain mux; it glitches if the source pin moves
    assign derived_clock_out_x1x4 = pass_sel ? ref_clk_in : clk125_q;
    assign derived_clock_out_x8   = clk250_q;
    assign app_clk_out            = app_q;

    ////////////////////////////////////////////////////////////////////////
    // Sticky and non-sticky configuration state
    ////////////////////////////////////////////////////////////////////////

    logic [STICKY_W-1:0] sticky_q, sticky_d;
    logic [CFG_W-1:0]    cfg_q, cfg_d;
    logic                busy_q, busy_d;
    logic                glob_meta_q, glob_meta_d;
    logic                glob_sync_q, glob_sync_d;

    // Sticky state ignores every reset but power-on
    always_comb begin
        sticky_d = sticky_we_in ? sticky_wd_in : sticky_q;
    end

    // R15 sticky survival
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sticky_q <= STICKY_RST;
        end else begin
            sticky_q <= sticky_d;
        end
    end

    // Non-sticky config and datapath state
    always_comb begin
        cfg_d  = cfg_we_in ? cfg_wd_in : cfg_q;
        // Datapath stays idle until the global reset release has settled
        busy_d = stat_in.dl_up && glob_sync_q;
        // R10 config reset
        if (crst_in) begin
            cfg_d = CFG_RST;
        end
        // R09 datapath reset
        if (srst_in) begin
            busy_d = 1'b0;
        end
    end

    // Release stages; busy reads only the second flop
    always_comb begin
        glob_meta_d = 1'b1;
        glob_sync_d = glob_meta_q;
    end

    // Release of the x8 global reset is synchronised for busy, not for cfg_q; assertion stays async
    always_ff @(posedge clk_in or negedge glob_nrst_in) begin
        if (!glob_nrst_in) begin
            glob_meta_q <= 1'b0;
            glob_sync_q <= 1'b0;
        end else begin
            glob_meta_q <= glob_meta_d;
            glob_sync_q <= glob_sync_d;
        end
    end

    // R06 global reset
    always_ff @(posedge clk_in or negedge nrst_in or negedge glob_nrst_in) begin
        if (!nrst_in || !glob_nrst_in) begin
            cfg_q  <= CFG_RST;
            busy_q <= 1'b0;
        end else begin
            cfg_q  <= cfg_d;
            busy_q <= busy_d;
        end
    end

    assign sticky_out  = sticky_q;
    assign cfg_out     = cfg_q;
    assign dp_busy_out = busy_q;

    ////////////////////////////////////////////////////////////////////////
    // Reset exit indications
    ////////////////////////////////////////////////////////////////////////

    exit_s exits;

    // R17 partner samples these on the core clock
    exit_detect u_exit (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .stat_in  (stat_in),
        .exit_out (exits)
    );

    assign l2_exit_n_out   = exits.l2_exit_n;
    assign hot_exit_n_out  = exits.hot_exit_n;
    assign dlup_exit_n_out = exits.dlup_exit_n;

endmodule : clk_rst_core

// ===== hw/clk_rst_pkg.sv
// Summary of operation
// R01 - Partner supplies 125 MHz core clock; x1/x4 core I/O synchronous to it.
// R02 - Generic PIPE: reference clock passes straight through to the 125 MHz output.
// R03 - Transceiver PHY x1/x4: 125 MHz output derived from reference clock.
// R04 - x8 drives 250 MHz derived output; 125 MHz pins absent there.
// R05 - Partner feeds x8 core clock input at the 250 MHz output frequency.
// R06 - x8 active-low asynchronous global reset clears configuration and datapath logic.
// R07 - Active-low asynchronous power-on reset initialises sticky registers and clocking.
// R08 - 100 or 156.25 MHz reference: 125 MHz output held low during power-on reset.
// R09 - x1/x4 synchronous active-high datapath reset clears datapath state machines.
// R10 - x1/x4 synchronous active-high configuration reset clears only non-sticky registers.
// R11 - x1 application clock derived from reference, 125 or 62.5 MHz.
// R12 - Low-power exit indication low when LTSSM leaves L2, else high.
// R13 - Hot-reset exit indication pulses low one cycle leaving hot reset.
// R14 - Link-down indication low on transition from link up to link down.
// R15 - Sticky registers cleared only by power-on reset, surviving all others.
// R16 - Partner should combine board power-on reset with card reset pin.
// R17 - Partner asserts both synchronous resets after sampling any exit indication low.
package clk_rst_pkg;

    // Clock source selection for the x1/x4 derived output
    typedef enum logic [1:0] {
        SRC_PIPE      = 2'h0,  // Reference passes through
        SRC_REF_100   = 2'h1,  // Reference runs at 100 MHz
        SRC_REF_125   = 2'h2,  // Reference already 125 MHz
        SRC_REF_15625 = 2'h3   // Reference at 156.25 MHz
    } clk_src_e;

    // Link training states seen by the exit detectors
    typedef enum logic [3:0] {
        LTS_OTHER  = 4'h1,
        LTS_L2     = 4'h2,
        LTS_HOTRST = 4'h4,
        LTS_ACTIVE = 4'h8
    } ltssm_e;

    // Status flags from the link layer
    typedef struct packed {
        ltssm_e ltssm;
        logic   dl_up;
    } link_stat_s;

    // Exit indications, all active low
    typedef struct packed {
        logic l2_exit_n;
        logic hot_exit_n;
        logic dlup_exit_n;
    } exit_s;

    localparam int unsigned        STICKY_W      = 16;
    localparam int unsigned        CFG_W         = 16;
    localparam logic [STICKY_W-1:0] STICKY_RST   = 16'h0000;
    localparam logic [CFG_W-1:0]   CFG_RST       = 16'h0000;
    localparam exit_s              EXIT_IDLE     = 3'h7;
    localparam ltssm_e             LTS_RST       = LTS_OTHER;
    localparam logic [1:0]         DIV_RST       = 2'h0;

endpackage : clk_rst_pkg

// ===== hw/exit_detect.sv
module exit_detect
    import clk_rst_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire link_stat_s stat_in,
    output exit_s           exit_out
);

    ltssm_e ltssm_q, ltssm_d;
    logic   dlup_q, dlup_d;
    exit_s  exit_q, exit_d;

    // Edge detection on the link state
    always_comb begin
        ltssm_d = stat_in.ltssm;
        dlup_d  = stat_in.dl_up;
        exit_d  = EXIT_IDLE;
        // R12 L2 leave
        if (ltssm_q == LTS_L2 && stat_in.ltssm != LTS_L2) begin
            exit_d.l2_exit_n = 1'b0;
        end
        // R13 single-cycle pulse
        if (ltssm_q == LTS_HOTRST && stat_in.ltssm != LTS_HOTRST) begin
            exit_d.hot_exit_n = 1'b0;
        end
        // R14 link down
        if (dlup_q && !stat_in.dl_up) begin
            exit_d.dlup_exit_n = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ltssm_q <= LTS_RST;
            dlup_q  <= 1'b0;
            exit_q  <= EXIT_IDLE;
        end else begin
            ltssm_q <= ltssm_d;
            dlup_q  <= dlup_d;
            exit_q  <= exit_d;
        end
    end

    assign exit_out = exit_q;

endmodule : exit_detect
